// >>> core/option_pkg.sv
// Package with option word layouts, register map and timing constants
package option_pkg;
  localparam int unsigned WORD_W = 15;
  localparam logic [14:0] WORD0_RESET = 15'h7FFF;
  localparam logic [14:0] WORD1_RESET = 15'h7FFF;
  localparam logic [14:0] WORD2_RESET = 15'h3FBF;
  localparam logic [14:0] WORDD_RESET = 15'h7FFF;
  // Word 0 fields
  localparam int unsigned W0_WARMUP = 13;
  localparam int unsigned W0_RESET_MODE = 10;
  localparam int unsigned W0_LVR_HI = 8;
  localparam int unsigned W0_LVR_LO = 7;
  localparam int unsigned W0_RESET_PIN = 6;
  localparam int unsigned W0_WDT_N = 5;
  localparam int unsigned W0_NOISE_LEN = 4;
  localparam int unsigned W0_NOISE_EN = 3;
  localparam int unsigned W0_PROTECT_HI = 2;
  // Word 1 fields
  localparam int unsigned W1_SLOW_SEL = 13;
  localparam int unsigned W1_TRIM_HI = 12;
  localparam int unsigned W1_TRIM_LO = 7;
  localparam int unsigned W1_RCM_HI = 6;
  localparam int unsigned W1_RCM_LO = 5;
  localparam int unsigned W1_ADDR_SRC = 4;
  localparam int unsigned W1_OSC_SEL = 1;
  localparam int unsigned W1_CLKOUT = 0;
  // Word 2 and address word fields
  localparam int unsigned W2_STRIM_HI = 11;
  localparam int unsigned W2_STRIM_LO = 8;
  localparam int unsigned WD_ADDR_HI = 6;
  // Decoded constants
  localparam logic [7:0] WARMUP_LONG = 8'h20;
  localparam logic [7:0] WARMUP_SHORT = 8'h08;
  localparam logic [7:0] NOISE_SHORT = 8'h08;
  localparam logic [7:0] NOISE_LONG = 8'h20;
  localparam logic [6:0] FIXED_SLAVE_ADDR = 7'h77;
  localparam logic [6:0] SLOW_KHZ_FAST = 7'h40;
  localparam logic [6:0] SLOW_KHZ_SLOW = 7'h10;
  localparam logic [6:0] WDT_KHZ = 7'h10;
  localparam logic [4:0] RC_MHZ_00 = 5'h0C;
  localparam logic [4:0] RC_MHZ_01 = 5'h08;
  localparam logic [4:0] RC_MHZ_10 = 5'h10;
  localparam logic [4:0] RC_MHZ_11 = 5'h04;
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_WORD1 = 8'h04;
  localparam logic [7:0] ADDR_WORD2 = 8'h08;
  localparam logic [7:0] ADDR_WORDD = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {LVR_POR_ONLY, LVR_LOW_PAIR, LVR_HIGH_PAIR} lvr_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_GREEN, MODE_IDLE, MODE_SLEEP} run_mode_t;
endpackage

// >>> core/option_ahb_slave.sv
// AHB-Lite slave reading the captured option words and a run-mode register
`timescale 1ns/1ps
`default_nettype none
module option_ahb_slave (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rd_word0,
  input wire logic [31:0] rd_word1,
  input wire logic [31:0] rd_word2,
  input wire logic [31:0] rd_wordd,
  input wire logic [31:0] rd_status,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [1:0] mode_q
);
  logic wr_pend_q, wr_pend_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] mode_d;

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] w0,
    input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] wd,
    input logic [31:0] st, input logic [1:0] md);
    if (a == option_pkg::ADDR_WORD0) read_mux = w0;
    else if (a == option_pkg::ADDR_WORD1) read_mux = w1;
    else if (a == option_pkg::ADDR_WORD2) read_mux = w2;
    else if (a == option_pkg::ADDR_WORDD) read_mux = wd;
    else if (a == option_pkg::ADDR_STATUS) read_mux = st;
    else if (a == option_pkg::ADDR_MODE) read_mux = {30'h0, md};
    else read_mux = 32'h0;
  endfunction

  always_comb begin
    wr_pend_d = 1'b0;
    addr_d = addr_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    if (wr_pend_q && addr_q == option_pkg::ADDR_MODE) begin
      mode_d = hwdata[1:0];
    end
    if (hready && hsel && htrans == option_pkg::HTRANS_NONSEQ) begin
      addr_d = haddr;
      wr_pend_d = hwrite;
      if (!hwrite) begin
        rdata_d = read_mux(haddr, rd_word0, rd_word1, rd_word2, rd_wordd, rd_status, mode_d);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0;
      mode_q <= 2'h0;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// >>> core/option_word_config_decoder.sv
// Option word decoder: captures option words at reset, drives static settings
//
// Overview of operation
// - Warm-up back to normal is 32 clocks when select is 0, else 8.
// - After reset enter green mode when select bit is 0, normal when 1; the code only outputs the bit and mode_q always resets to normal.
// - Voltage field 1x power-on only, 01 lower pair, 00 higher pair.
// - Reset pin select 0 gives active-low reset input, 1 gives port pin.
// - Noise filter valid pulse is 8 clocks when bit is 0, 32 when 1.
// - Noise filter bypassed when enable bit is 0, active when 1.
// - Noise filter is forced off in green, idle or sleep mode.
// - Protect field all zeros enables protection, all ones disables it.
// - Slow clock is 64 kHz when select is 0, 16 kHz when 1.
// - Watchdog clock stays 16 kHz whatever the slow clock select.
// - Six-bit field supplies the main RC trim value.
// - RC frequency: 00 12 MHz, 01 8 MHz, 10 16 MHz, 11 4 MHz.
// - Slave address is 0x77 when source bit is 1, user address when 0.
// - Oscillator select 1 makes clock-out a port pin, 0 a clock output.
// - Clock-out bit 0 gives open-drain pin, 1 drives instruction clock.
// - Four-bit field supplies the slow RC trim value.
// - A separate word holds the seven-bit user slave address.
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module option_word_config_decoder (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [14:0] option_word_zero,
  input wire logic [14:0] option_word_one,
  input wire logic [14:0] option_word_two,
  input wire logic [14:0] option_word_addr,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [7:0] rc_warmup_clocks,
  output logic reset_speed_mode_select,
  output logic [1:0] low_voltage_reset_level,
  output logic reset_pin_is_reset,
  output logic watchdog_on,
  output logic [7:0] noise_pulse_clocks,
  output logic noise_filter_active,
  output logic code_protect_on,
  output logic [6:0] slow_clock_khz,
  output logic [6:0] watchdog_clock_khz,
  output logic [5:0] main_rc_trim,
  output logic [4:0] rc_frequency_mhz,
  output logic [6:0] slave_address,
  output logic clock_output_pin_is_clock,
  output logic clock_output_drives
);
  // ----------------------------------------------------------------
  // Option word capture
  // ----------------------------------------------------------------
  // Words are sampled on every reset cycle, so the last cycle of reset wins;
  // the nonvolatile store must be stable before reset is released.
  logic [14:0] w0_q, w0_d, w1_q, w1_d, w2_q, w2_d, wd_q, wd_d;
  logic [1:0] mode_q;

  always_comb begin
    w0_d = w0_q;
    w1_d = w1_q;
    w2_d = w2_q;
    wd_d = wd_q;
    if (srst) begin
      w0_d = option_word_zero;
      w1_d = option_word_one;
      w2_d = option_word_two;
      wd_d = option_word_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    w0_q <= w0_d;
    w1_q <= w1_d;
    w2_q <= w2_d;
    wd_q <= wd_d;
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  logic [7:0] warm_d, noise_len_d;
  logic [1:0] lvr_d;
  logic [6:0] slow_d, addr_d;
  logic [4:0] mhz_d;
  logic protect_d, filter_d, quiet_mode;
  logic [2:0] prot_field;
  logic speed_sel_d, rst_pin_d, wdt_on_d, clk_pin_d, clk_drv_d;
  logic [6:0] wdt_khz_d;
  logic [5:0] trim_d;

  always_comb begin
    warm_d = w0_q[option_pkg::W0_WARMUP] ? option_pkg::WARMUP_SHORT
                                         : option_pkg::WARMUP_LONG;
    if (w0_q[option_pkg::W0_LVR_HI]) begin
      lvr_d = option_pkg::LVR_POR_ONLY;
    end else if (w0_q[option_pkg::W0_LVR_LO]) begin
      lvr_d = option_pkg::LVR_LOW_PAIR;
    end else begin
      lvr_d = option_pkg::LVR_HIGH_PAIR;
    end
    noise_len_d = w0_q[option_pkg::W0_NOISE_LEN] ? option_pkg::NOISE_LONG
                                                 : option_pkg::NOISE_SHORT;
    quiet_mode = mode_q != option_pkg::MODE_NORMAL;
    filter_d = w0_q[option_pkg::W0_NOISE_EN] && !quiet_mode;
    prot_field = w0_q[option_pkg::W0_PROTECT_HI:0];
    // Mixed patterns are undefined; they are treated as protected, the safe side.
    protect_d = prot_field != 3'h7;
    slow_d = w1_q[option_pkg::W1_SLOW_SEL] ? option_pkg::SLOW_KHZ_SLOW
                                           : option_pkg::SLOW_KHZ_FAST;
    case (w1_q[option_pkg::W1_RCM_HI:option_pkg::W1_RCM_LO])
      2'h0: mhz_d = option_pkg::RC_MHZ_00;
      2'h1: mhz_d = option_pkg::RC_MHZ_01;
      2'h2: mhz_d = option_pkg::RC_MHZ_10;
      default: mhz_d = option_pkg::RC_MHZ_11;
    endcase
    addr_d = w1_q[option_pkg::W1_ADDR_SRC] ? option_pkg::FIXED_SLAVE_ADDR
                                           : wd_q[option_pkg::WD_ADDR_HI:0];
    speed_sel_d = w0_q[option_pkg::W0_RESET_MODE];
    rst_pin_d = !w0_q[option_pkg::W0_RESET_PIN];
    wdt_on_d = !w0_q[option_pkg::W0_WDT_N];
    wdt_khz_d = option_pkg::WDT_KHZ;
    trim_d = w1_q[option_pkg::W1_TRIM_HI:option_pkg::W1_TRIM_LO];
    clk_pin_d = !w1_q[option_pkg::W1_OSC_SEL];
    clk_drv_d = w1_q[option_pkg::W1_CLKOUT];
  end

  // Settings register on the cycle after the words, so outputs come from flops
  always_ff @(posedge clk_sys) begin
    rc_warmup_clocks <= warm_d;
    reset_speed_mode_select <= speed_sel_d;
    low_voltage_reset_level <= lvr_d;
    reset_pin_is_reset <= rst_pin_d;
    watchdog_on <= wdt_on_d;
    noise_pulse_clocks <= noise_len_d;
    noise_filter_active <= filter_d;
    code_protect_on <= protect_d;
    slow_clock_khz <= slow_d;
    watchdog_clock_khz <= wdt_khz_d;
    main_rc_trim <= trim_d;
    rc_frequency_mhz <= mhz_d;
    slave_address <= addr_d;
    clock_output_pin_is_clock <= clk_pin_d;
    clock_output_drives <= clk_drv_d;
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [3:0] slow_trim;
  logic word2_ok;
  assign slow_trim = w2_q[option_pkg::W2_STRIM_HI:option_pkg::W2_STRIM_LO];
  // Flags an image whose fixed bits match the programmed pattern.
  assign word2_ok = (w2_q & 15'h70FF) == (option_pkg::WORD2_RESET & 15'h70FF);
  assign status_word = {22'h0, word2_ok, slow_trim, noise_filter_active,
                        code_protect_on, watchdog_on, reset_pin_is_reset, 1'b0};

  option_ahb_slave u_bus (
    .clk_sys(clk_sys),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .rd_word0({17'h0, w0_q}),
    .rd_word1({17'h0, w1_q}),
    .rd_word2({17'h0, w2_q}),
    .rd_wordd({17'h0, wd_q}),
    .rd_status(status_word),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .mode_q(mode_q)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Marks a status read taken at the last edge, for the bus checks below
  logic status_rd_q, status_rd_d;
  always_comb begin
    status_rd_d = !srst && hsel && hready && !hwrite && haddr == option_pkg::ADDR_STATUS
                  && htrans == option_pkg::HTRANS_NONSEQ;
  end
  always_ff @(posedge clk_sys) begin
    status_rd_q <= status_rd_d;
  end

  a_warmup_length: assert property (@(posedge clk_sys) disable iff (srst)
    rc_warmup_clocks == ($past(w0_q[13]) ? 8'h08 : 8'h20))
    else $error("warm-up length wrong");
  a_reset_mode: assert property (@(posedge clk_sys) disable iff (srst)
    reset_speed_mode_select == $past(w0_q[10]))
    else $error("reset speed mode wrong");
  a_lvr_decode: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w0_q[8:7]) == 2'h0 |-> low_voltage_reset_level == 2'h2)
    else $error("voltage level decode wrong");
  a_noise_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    $past(mode_q) != 2'h0 |-> !noise_filter_active)
    else $error("filter on in low-power mode");
  a_protect_clear: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w0_q[2:0]) == 3'h7 |-> !code_protect_on)
    else $error("protection decode wrong");
  a_rc_freq: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w1_q[6:5]) == 2'h2 |-> rc_frequency_mhz == 5'h10)
    else $error("rc frequency wrong");
  a_slave_addr: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w1_q[4]) |-> slave_address == 7'h77)
    else $error("fixed slave address wrong");
  a_hold_words: assert property (@(posedge clk_sys) disable iff (srst)
    $stable(w0_q) && $stable(w1_q) && $stable(w2_q) && $stable(wd_q))
    else $error("option word changed outside reset");

  // ----------------------------------------------------------------
  // Checks on word zero settings
  // ----------------------------------------------------------------
  a_lvr_low_pair: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w0_q[8:7]) == 2'h1 |-> low_voltage_reset_level == option_pkg::LVR_LOW_PAIR)
    else $error("lower voltage pair decode wrong");

  a_lvr_por_only: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w0_q[8]) |-> low_voltage_reset_level == option_pkg::LVR_POR_ONLY)
    else $error("power-on only decode wrong");

  a_reset_pin: assert property (@(posedge clk_sys) disable iff (srst)
    reset_pin_is_reset == !$past(w0_q[6]))
    else $error("reset pin function wrong");

  a_watchdog_enable: assert property (@(posedge clk_sys) disable iff (srst)
    watchdog_on == !$past(w0_q[5]))
    else $error("watchdog enable wrong");

  a_noise_length: assert property (@(posedge clk_sys) disable iff (srst)
    noise_pulse_clocks == ($past(w0_q[4]) ? 8'h20 : 8'h08))
    else $error("noise pulse length wrong");

  a_noise_bypass: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(w0_q[3]) |-> !noise_filter_active)
    else $error("filter on while bypassed");

  a_noise_enable: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w0_q[3]) && $past(mode_q) == 2'h0 |-> noise_filter_active)
    else $error("filter off in normal mode");

  a_protect_set: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w0_q[2:0]) != 3'h7 |-> code_protect_on)
    else $error("protection not applied");

  // ----------------------------------------------------------------
  // Checks on word one settings
  // ----------------------------------------------------------------
  a_slow_clock: assert property (@(posedge clk_sys) disable iff (srst)
    slow_clock_khz == ($past(w1_q[13]) ? 7'h10 : 7'h40))
    else $error("slow clock select wrong");

  a_main_trim: assert property (@(posedge clk_sys) disable iff (srst)
    main_rc_trim == $past(w1_q[12:7]))
    else $error("main trim wrong");

  a_rc_freq_twelve: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w1_q[6:5]) == 2'h0 |-> rc_frequency_mhz == 5'h0C)
    else $error("rc frequency code 0 wrong");

  a_rc_freq_eight: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w1_q[6:5]) == 2'h1 |-> rc_frequency_mhz == 5'h08)
    else $error("rc frequency code 1 wrong");

  a_rc_freq_four: assert property (@(posedge clk_sys) disable iff (srst)
    $past(w1_q[6:5]) == 2'h3 |-> rc_frequency_mhz == 5'h04)
    else $error("rc frequency code 3 wrong");

  a_user_addr: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(w1_q[4]) |-> slave_address == $past(wd_q[6:0]))
    else $error("user slave address wrong");

  a_clock_pin: assert property (@(posedge clk_sys) disable iff (srst)
    clock_output_pin_is_clock == !$past(w1_q[1]))
    else $error("clock pin function wrong");

  a_clock_drive: assert property (@(posedge clk_sys) disable iff (srst)
    clock_output_drives == $past(w1_q[0]))
    else $error("clock pin drive wrong");

  // ----------------------------------------------------------------
  // Checks on holding and status
  // ----------------------------------------------------------------
  // The filter flag is left out: it follows the run mode.
  a_hold_settings: assert property (@(posedge clk_sys) disable iff (srst)
    $stable(rc_warmup_clocks) && $stable(low_voltage_reset_level) && $stable(watchdog_on)
    && $stable(code_protect_on) && $stable(rc_frequency_mhz) && $stable(slave_address)
    && $stable(main_rc_trim))
    else $error("setting changed outside reset");

  a_slow_trim_read: assert property (@(posedge clk_sys) disable iff (srst)
    status_rd_q |-> hrdata[8:5] == $past(w2_q[11:8]))
    else $error("slow trim in status wrong");

  a_word2_flag: assert property (@(posedge clk_sys) disable iff (srst)
    status_rd_q |-> hrdata[9] == ($past(w2_q[14:12]) == 3'h3 && $past(w2_q[7:0]) == 8'hBF))
    else $error("word two pattern flag wrong");
endmodule
`default_nettype wire

// >>> testbench/option_word_config_decoder_tb_top.sv
// Self-checking testbench for the option word decoder
`timescale 1ns/1ps
`default_nettype none
module option_word_config_decoder_tb_top;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic [14:0] w0 = 15'h7FFF;
  logic [14:0] w1 = 15'h7FFF;
  logic [14:0] w2 = 15'h3FBF;
  logic [14:0] wd = 15'h7FFF;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rs_sel, rst_pin, wdt_on, nf_on, cp_on, clk_pin, clk_drv;
  logic [7:0] warm, npc;
  logic [1:0] lvr, md;
  logic [6:0] slow_khz, wdt_khz, slv;
  logic [5:0] trim;
  logic [4:0] mhz;
  logic [14:0] ew [4];
  int num_errors = 0;
  int total_checks = 0;

  option_word_config_decoder u_option_word_config_decoder (
    .clk_sys(clk_sys), .srst(srst), .option_word_zero(w0), .option_word_one(w1),
    .option_word_two(w2), .option_word_addr(wd), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rc_warmup_clocks(warm), .reset_speed_mode_select(rs_sel),
    .low_voltage_reset_level(lvr), .reset_pin_is_reset(rst_pin), .watchdog_on(wdt_on),
    .noise_pulse_clocks(npc), .noise_filter_active(nf_on), .code_protect_on(cp_on),
    .slow_clock_khz(slow_khz), .watchdog_clock_khz(wdt_khz), .main_rc_trim(trim),
    .rc_frequency_mhz(mhz), .slave_address(slv), .clock_output_pin_is_clock(clk_pin),
    .clock_output_drives(clk_drv)
  );

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One single transfer; the answer is awaited, never assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= option_pkg::HTRANS_NONSEQ;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= v;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1) @(posedge clk_sys);
    d = hrdata;
  endtask

  // Words are scrambled right after release so any late capture shows up
  task automatic do_reset(input logic [14:0] a, b, c, e);
    w0 <= a;
    w1 <= b;
    w2 <= c;
    wd <= e;
    ew = '{a, b, c, e};
    md = 2'h0;
    srst <= 1'h1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'h0;
    w0 <= ~a;
    w1 <= ~b;
    w2 <= ~c;
    wd <= ~e;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic check_all();
    logic [31:0] d;
    logic [4:0] f;
    logic nf, pat;
    logic [1:0] lv;
    f = ew[1][6:5] == 2'h0 ? 5'h0C : ew[1][6:5] == 2'h1 ? 5'h08 :
        ew[1][6:5] == 2'h2 ? 5'h10 : 5'h04;
    lv = ew[0][8] ? option_pkg::LVR_POR_ONLY :
         ew[0][7] ? option_pkg::LVR_LOW_PAIR : option_pkg::LVR_HIGH_PAIR;
    nf = ew[0][3] && md == 2'h0;
    pat = !ew[2][14] && !ew[2][6] && ew[2][13:12] == 2'h3 && ew[2][7] && ew[2][5:0] == 6'h3F;
    chk(32'(warm), ew[0][13] ? 32'h08 : 32'h20);
    chk(32'(rs_sel), 32'(ew[0][10]));
    chk(32'(lvr), 32'(lv));
    chk(32'(rst_pin), 32'(!ew[0][6]));
    chk(32'(wdt_on), 32'(!ew[0][5]));
    chk(32'(npc), ew[0][4] ? 32'h20 : 32'h08);
    chk(32'(nf_on), 32'(nf));
    chk(32'(cp_on), 32'(ew[0][2:0] != 3'h7));
    chk(32'(slow_khz), ew[1][13] ? 32'h10 : 32'h40);
    chk(32'(wdt_khz), 32'h10);
    chk(32'(trim), 32'(ew[1][12:7]));
    chk(32'(mhz), 32'(f));
    chk(32'(slv), ew[1][4] ? 32'h77 : 32'(ew[3][6:0]));
    chk(32'(clk_pin), 32'(!ew[1][1]));
    chk(32'(clk_drv), 32'(ew[1][0]));
    chk(32'(hresp), 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'h0, 8'(4 * i), 32'h0, d);
      chk(d, {17'h0, ew[i]});
    end
    xfer(1'h0, option_pkg::ADDR_STATUS, 32'h0, d);
    chk(32'(d[9:1]), 32'({pat, ew[2][11:8], nf, ew[0][2:0] != 3'h7, !ew[0][5], !ew[0][6]}));
  endtask

  task automatic t_defaults();
    do_reset(option_pkg::WORD0_RESET, option_pkg::WORD1_RESET, option_pkg::WORD2_RESET,
             option_pkg::WORDD_RESET);
    check_all();
  endtask

  task automatic t_opposite();
    do_reset(15'h0000, 15'h0000, 15'h0A55, 15'h002A);
    check_all();
  endtask

  // Walks every voltage level and frequency code, with mixed protect patterns
  task automatic t_table();
    for (int i = 0; i < 4; i++) begin
      do_reset({6'h3F, 2'(i), 4'(i * 5), 3'(i + 1)}, {8'(i * 37), 2'(i), 5'(i * 7)},
               {3'h3, 4'(i * 5), 8'hBF}, {8'h00, 7'(i * 19)});
      check_all();
    end
  endtask

  task automatic t_mode();
    logic [31:0] d;
    do_reset(option_pkg::WORD0_RESET, 15'h7FEF, option_pkg::WORD2_RESET, 15'h0055);
    for (int m = 3; m >= 0; m--) begin
      xfer(1'h1, option_pkg::ADDR_MODE, 32'(m), d);
      xfer(1'h0, option_pkg::ADDR_MODE, 32'h0, d);
      chk(d, 32'(m));
      md = 2'(m);
      repeat (2) @(posedge clk_sys);
      check_all();
    end
    xfer(1'h1, option_pkg::ADDR_WORD0, 32'h0000, d);
    xfer(1'h0, option_pkg::ADDR_WORD0, 32'h0, d);
    chk(d, {17'h0, ew[0]});
    xfer(1'h0, 8'h1C, 32'h0, d);
    chk(d, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("unexpected hang at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    t_defaults();
    t_opposite();
    t_table();
    t_mode();
    end_of_test();
  end
endmodule
`default_nettype wire
